// ===== src/dma_defines.svh
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH
// ****************************************
// descriptor field selects
// ****************************************
`define SEL_SRC_PTR   4'h0
`define SEL_SRC_STEP  4'h1
`define SEL_SRC_ATTR  4'h2
`define SEL_SRC_FINAL 4'h3
`define SEL_DST_PTR   4'h4
`define SEL_DST_STEP  4'h5
`define SEL_DST_ATTR  4'h6
`define SEL_DST_FINAL 4'h7
`define SEL_MINOR     4'h8
`define SEL_ITER      4'h9
`define SEL_CTRL      4'hA
// ****************************************
// field positions, codes, reset values
// ****************************************
`define ATTR_MOD_LSB  3
`define ITER_BI_LSB   16
`define CTRL_START    0
`define CTRL_IMAJ     1
`define SZ_BYTE       3'h0
`define SZ_HALF       3'h1
`define DESC_RST      32'h0000_0000
`endif

// ===== src/dma_pkg.sv
package dma_pkg;
    // engine states, gray along idle-load-xfer-wback
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOAD  = 2'b01,
        ST_XFER  = 2'b11,
        ST_WBACK = 2'b10
    } eng_state_t;
    typedef logic [31:0] addr_t;
    typedef logic [2:0]  width_t;
endpackage

// ===== src/dma_pair_buf.sv
`timescale 1ns/1ps
`default_nettype none
module dma_pair_buf #(
    parameter int W     = 35,
    parameter int DEPTH = 2
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("buffer depth must be a power of two of at least 2");
    end
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp, rp;
        logic [AW:0]             cnt;
    } buf_t;
    buf_t r, n;
    logic push, pop;
    // honest flags straight from the count
    assign o_ready = r.cnt != (AW+1)'(DEPTH);
    assign o_valid = r.cnt != '0;
    assign o_data  = r.mem[r.rp];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    // next state
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = i_data;
            n.wp        = r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = r.rp + 1'b1;
        end
        n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    // state register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule
`default_nettype wire

// ===== src/dma_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module dma_arbiter #(
    parameter int NGRP = 2,
    parameter int GCH  = 4,
    parameter int PW   = 2,
    parameter int NCH  = NGRP * GCH,
    parameter int CW   = $clog2(NCH)
) (
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    input  wire logic [NCH-1:0]     i_req,
    input  wire logic               i_grp_rr,
    input  wire logic               i_ch_rr,
    input  wire logic [NCH*PW-1:0]  i_ch_prio,
    input  wire logic [NGRP*PW-1:0] i_grp_prio,
    input  wire logic               i_take,
    output logic                    o_valid,
    output logic [CW-1:0]           o_ch
);
    localparam int GW = $clog2(NGRP);
    localparam int LW = $clog2(GCH);
    typedef struct packed {
        logic [GW-1:0]           lgrp;
        logic [NGRP-1:0][LW-1:0] lch;
    } arb_t;
    arb_t r, n;
    logic [NGRP-1:0] gv;
    logic [GCH-1:0]  cv;
    int              g, c;

    // fixed pick: highest level wins, a tie goes to the lower number
    function automatic int fix_pick(logic [NCH-1:0] v, logic [NCH*PW-1:0] p, int cnt);
        int          best;
        logic [PW-1:0] bp;
        best = -1;
        bp   = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (i < cnt && v[i] && (best < 0 || p[i*PW +: PW] >= bp)) begin
                best = i;
                bp   = p[i*PW +: PW];
            end
        end
        return (best < 0) ? 0 : best;
    endfunction

    // rotate downward from the last serviced index, wrapping to the top
    function automatic int rr_down(logic [NCH-1:0] v, int cnt, int last);
        int pick;
        pick = 0;
        for (int k = NCH; k >= 1; k--) begin
            if (k <= cnt && v[(last - k + cnt) % cnt]) begin
                pick = (last - k + cnt) % cnt;
            end
        end
        return pick;
    endfunction

    // selection and pointer update; pointers move only on a taken grant
    always_comb begin
        n = r;
        for (int i = 0; i < NGRP; i++) begin
            gv[i] = |i_req[i*GCH +: GCH];
        end
        g = i_grp_rr ? rr_down(NCH'(gv), NGRP, int'(r.lgrp)) :
                       fix_pick(NCH'(gv), (NCH*PW)'(i_grp_prio), NGRP);
        cv = i_req[g*GCH +: GCH];
        c = i_ch_rr ? rr_down(NCH'(cv), GCH, int'(r.lch[g])) :
                      fix_pick(NCH'(cv), (NCH*PW)'(i_ch_prio[g*GCH*PW +: GCH*PW]), GCH);
        if (i_take) begin
            n.lgrp   = GW'(g);
            n.lch[g] = LW'(c);
        end
    end
    assign o_valid = |i_req;
    assign o_ch    = CW'(g * GCH + c);
    // rotation pointers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule
`default_nettype wire

// ===== src/dma_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_defines.svh"
module dma_engine #(
    parameter int NGRP = 2,
    parameter int GCH  = 4,
    parameter int PW   = 2,
    parameter int NCH  = NGRP * GCH,
    parameter int CW   = $clog2(NCH)
) (
    input  wire logic               I_CORE_CLK,
    input  wire logic               I_RST_N,
    // descriptor write port
    input  wire logic               I_DESC_WE,
    input  wire logic [CW-1:0]      I_DESC_CH,
    input  wire logic [3:0]         I_DESC_SEL,
    input  wire logic [31:0]        I_DESC_DATA,
    // arbitration setup and requests
    input  wire logic               I_GRP_RR,
    input  wire logic               I_CH_RR,
    input  wire logic [NCH*PW-1:0]  I_CH_PRIO,
    input  wire logic [NGRP*PW-1:0] I_GRP_PRIO,
    input  wire logic [NCH-1:0]     I_HW_REQUEST_ENABLE,
    input  wire logic [NCH-1:0]     I_HW_REQ,
    input  wire logic [NCH-1:0]     I_IRQ_CLR,
    // read master
    output var dma_pkg::addr_t      O_RD_ADDR,
    output var dma_pkg::width_t     O_RD_WIDTH,
    output logic                    O_RD_REQ,
    input  wire logic               I_RD_ACK,
    input  wire logic [31:0]        I_RD_DATA,
    // write master
    output var dma_pkg::addr_t      O_WR_ADDR,
    output var dma_pkg::width_t     O_WR_WIDTH,
    output logic [31:0]             O_WR_DATA,
    output logic                    O_WR_REQ,
    input  wire logic               I_WR_ACK,
    // status
    output logic [NCH-1:0]          O_START,
    output logic [NCH-1:0]          O_ACTIVE,
    output logic [NCH-1:0]          O_DONE,
    output logic [NCH-1:0]          O_CHANNEL_IRQ_FLAG,
    output logic [NCH-1:0]          O_HW_ACK,
    output logic                    O_BUSY,
    output logic [CW-1:0]           O_CUR_CH
);
    import dma_pkg::*;
    if (NGRP < 2 || GCH < 2 || PW < 1 || NCH > 64) begin : g_chk
        $error("engine needs 2+ groups, 2+ channels per group, at most 64");
    end
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        eng_state_t              st;
        logic [NCH-1:0][31:0]    sp, sf, dp, df, nb;
        logic [NCH-1:0][15:0]    ss, ds;
        logic [NCH-1:0][2:0]     sw, dw;
        logic [NCH-1:0][4:0]     sm, dm;
        logic [NCH-1:0][14:0]    ci, bi;
        logic [NCH-1:0]          start, act, done, imaj, irq, ack;
        logic [CW-1:0]           ch;
        logic [31:0]             wsrc, wdst, rleft, wleft, acc, wdat;
        logic [15:0]             wss, wds;
        logic [2:0]              wsw, wdw, fill;
        logic [4:0]              wsm, wdm;
        logic                    rd, wr;
    } eng_t;
    eng_t r, n;
    // ****************************************
    // helpers
    // ****************************************
    // signed step with optional modulo wrap of the low m bits
    function automatic logic [31:0] step_addr(logic [31:0] a, logic [15:0] s,
                                              logic [4:0] m);
        logic [31:0] sum, msk;
        sum = a + {{16{s[15]}}, s};
        msk = (32'h0000_0001 << m) - 32'h0000_0001;
        if (m == 5'h00) begin
            return sum;
        end
        return (a & ~msk) | (sum & msk);
    endfunction

    function automatic logic [2:0] bytes_of(logic [2:0] w);
        case (w)
            `SZ_BYTE: return 3'h1;
            `SZ_HALF: return 3'h2;
            default:  return 3'h4;
        endcase
    endfunction

    function automatic logic [31:0] lane_mask(logic [2:0] w);
        case (w)
            `SZ_BYTE: return 32'h0000_00FF;
            `SZ_HALF: return 32'h0000_FFFF;
            default:  return 32'hFFFF_FFFF;
        endcase
    endfunction
    // ****************************************
    // arbitration and data buffer
    // ****************************************
    logic [NCH-1:0] hwreq, req;
    logic           gv, take;
    logic [CW-1:0]  gch;
    logic           bin_v, bin_rdy, bout_v, bout_rdy;
    logic [34:0]    bin_d, bout_d;
    logic [31:0]    mrg;
    logic [3:0]     nf;

    // requests: start bits plus enabled peripheral lines, never the running one
    assign hwreq = I_HW_REQ & I_HW_REQUEST_ENABLE;
    assign req   = (r.start | hwreq) & ~r.act;

    dma_arbiter #(
        .NGRP (NGRP),
        .GCH  (GCH),
        .PW   (PW)
    ) u_arb (
        .i_clk      (I_CORE_CLK),
        .i_rst_n    (I_RST_N),
        .i_req      (req),
        .i_grp_rr   (I_GRP_RR),
        .i_ch_rr    (I_CH_RR),
        .i_ch_prio  (I_CH_PRIO),
        .i_grp_prio (I_GRP_PRIO),
        .i_take     (take),
        .o_valid    (gv),
        .o_ch       (gch)
    );

    // read words park here so a slow destination stalls the reads only once both entries are full
    assign bin_v    = r.rd && I_RD_ACK;
    assign bin_d    = {bytes_of(r.wsw), I_RD_DATA & lane_mask(r.wsw)};
    assign bout_rdy = (r.st == ST_XFER) && !r.wr;

    dma_pair_buf #(
        .W     (35),
        .DEPTH (2)
    ) u_buf (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_valid (bin_v),
        .o_ready (bin_rdy),
        .i_data  (bin_d),
        .o_valid (bout_v),
        .i_ready (bout_rdy),
        .o_data  (bout_d)
    );
    // ****************************************
    // engine next state
    // ****************************************
    always_comb begin
        n     = r;
        n.ack = '0;
        take  = 1'b0;
        mrg   = '0;
        nf    = '0;
        n.irq = r.irq & ~I_IRQ_CLR;
        unique case (r.st)
            ST_IDLE: begin
                // a channel switch only ever happens here, so nothing preempts
                if (gv) begin
                    take           = 1'b1;
                    n.ch           = gch;
                    n.done[gch]    = 1'b0;
                    n.start[gch]   = 1'b0;
                    n.act[gch]     = 1'b1;
                    n.ack[gch]     = hwreq[gch];
                    n.st           = ST_LOAD;
                end
            end
            ST_LOAD: begin
                n.wsrc  = r.sp[r.ch];
                n.wdst  = r.dp[r.ch];
                n.wss   = r.ss[r.ch];
                n.wds   = r.ds[r.ch];
                n.wsw   = r.sw[r.ch];
                n.wdw   = r.dw[r.ch];
                n.wsm   = r.sm[r.ch];
                n.wdm   = r.dm[r.ch];
                n.rleft = r.nb[r.ch];
                n.wleft = r.nb[r.ch];
                n.acc   = '0;
                n.fill  = '0;
                n.st    = ST_XFER;
            end
            ST_XFER: begin
                // one read in flight, issued only while the buffer has room
                if (!r.rd && r.rleft != '0 && bin_rdy) begin
                    n.rd = 1'b1;
                end
                if (r.rd && I_RD_ACK) begin
                    n.rd    = 1'b0;
                    n.wsrc  = step_addr(r.wsrc, r.wss, r.wsm);
                    n.rleft = r.rleft - 32'(bytes_of(r.wsw));
                end
                // pack source pieces little-endian into a destination word
                if (bout_v && bout_rdy) begin
                    mrg = r.acc | (bout_d[31:0] << {r.fill, 3'h0});
                    nf  = 4'(r.fill) + 4'(bout_d[34:32]);
                    if (nf >= 4'(bytes_of(r.wdw))) begin
                        n.wr   = 1'b1;
                        n.wdat = mrg;
                        n.acc  = '0;
                        n.fill = '0;
                    end else begin
                        n.acc  = mrg;
                        n.fill = nf[2:0];
                    end
                end
                if (r.wr && I_WR_ACK) begin
                    n.wr    = 1'b0;
                    n.wdst  = step_addr(r.wdst, r.wds, r.wdm);
                    n.wleft = r.wleft - 32'(bytes_of(r.wdw));
                end
                if (r.rleft == '0 && r.wleft == '0 && !r.wr && !r.rd) begin
                    n.st = ST_WBACK;
                end
            end
            ST_WBACK: begin
                n.act[r.ch] = 1'b0;
                if (r.ci[r.ch] == 15'h0001) begin
                    n.sp[r.ch]   = r.wsrc + r.sf[r.ch];
                    n.dp[r.ch]   = r.wdst + r.df[r.ch];
                    n.ci[r.ch]   = r.bi[r.ch];
                    n.done[r.ch] = 1'b1;
                    if (r.imaj[r.ch]) begin
                        n.irq[r.ch] = 1'b1;
                    end
                end else begin
                    n.sp[r.ch] = r.wsrc;
                    n.dp[r.ch] = r.wdst;
                    n.ci[r.ch] = r.ci[r.ch] - 15'h0001;
                end
                n.st = ST_IDLE;
            end
        endcase
        // software writes come last so a start set beats the engine's clear
        if (I_DESC_WE) begin
            unique case (I_DESC_SEL)
                `SEL_SRC_PTR:   n.sp[I_DESC_CH] = I_DESC_DATA;
                `SEL_SRC_STEP:  n.ss[I_DESC_CH] = I_DESC_DATA[15:0];
                `SEL_SRC_ATTR: begin
                    n.sw[I_DESC_CH] = I_DESC_DATA[2:0];
                    n.sm[I_DESC_CH] = I_DESC_DATA[`ATTR_MOD_LSB +: 5];
                end
                `SEL_SRC_FINAL: n.sf[I_DESC_CH] = I_DESC_DATA;
                `SEL_DST_PTR:   n.dp[I_DESC_CH] = I_DESC_DATA;
                `SEL_DST_STEP:  n.ds[I_DESC_CH] = I_DESC_DATA[15:0];
                `SEL_DST_ATTR: begin
                    n.dw[I_DESC_CH] = I_DESC_DATA[2:0];
                    n.dm[I_DESC_CH] = I_DESC_DATA[`ATTR_MOD_LSB +: 5];
                end
                `SEL_DST_FINAL: n.df[I_DESC_CH] = I_DESC_DATA;
                `SEL_MINOR:     n.nb[I_DESC_CH] = I_DESC_DATA;
                `SEL_ITER: begin
                    n.ci[I_DESC_CH] = I_DESC_DATA[14:0];
                    n.bi[I_DESC_CH] = I_DESC_DATA[`ITER_BI_LSB +: 15];
                end
                `SEL_CTRL: begin
                    n.imaj[I_DESC_CH] = I_DESC_DATA[`CTRL_IMAJ];
                    if (I_DESC_DATA[`CTRL_START]) begin
                        n.start[I_DESC_CH] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end
    // ****************************************
    // registers and outputs
    // ****************************************
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            r    <= '0;
            r.st <= ST_IDLE;
        end else begin
            r <= n;
        end
    end
    assign O_RD_ADDR          = r.wsrc;
    assign O_RD_WIDTH         = r.wsw;
    assign O_RD_REQ           = r.rd;
    assign O_WR_ADDR          = r.wdst;
    assign O_WR_WIDTH         = r.wdw;
    assign O_WR_DATA          = r.wdat;
    assign O_WR_REQ           = r.wr;
    assign O_START            = r.start;
    assign O_ACTIVE           = r.act;
    assign O_DONE             = r.done;
    assign O_CHANNEL_IRQ_FLAG = r.irq;
    assign O_HW_ACK           = r.ack;
    assign O_BUSY             = r.st != ST_IDLE;
    assign O_CUR_CH           = r.ch;
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    grant_mark_a: assert property (take |=> r.act[r.ch] && !r.done[r.ch] && r.st == ST_LOAD)
        else $error("grant did not mark channel active");
    load_copy_a: assert property (r.st == ST_LOAD |=> r.wsrc == $past(r.sp[r.ch]) &&
                                  r.wleft == $past(r.nb[r.ch]))
        else $error("working copy differs from descriptor");
    rd_hold_a: assert property (r.rd && !I_RD_ACK |=> r.rd && $stable(O_RD_ADDR))
        else $error("read request dropped before acknowledge");
    src_step_a: assert property (r.rd && I_RD_ACK && r.wsm == 5'h00 |=>
                                 r.wsrc == $past(r.wsrc) + {{16{$past(r.wss[15])}}, $past(r.wss)})
        else $error("source did not advance by its step");
    mod_upper_a: assert property (r.rd && I_RD_ACK && r.wsm != 5'h00 |=>
                                  ((r.wsrc ^ $past(r.wsrc)) >> $past(r.wsm)) == 32'h0)
        else $error("modulo step touched upper address bits");
    minor_end_a: assert property (r.st == ST_WBACK && r.ci[r.ch] != 15'h0001 |=>
                                  !r.act[r.ch] && r.ci[r.ch] == $past(r.ci[r.ch]) - 15'h0001)
        else $error("minor retire wrote back wrong count");
    major_end_a: assert property (r.st == ST_WBACK && r.ci[r.ch] == 15'h0001 |=>
                                  r.done[r.ch] && r.ci[r.ch] == $past(r.bi[r.ch]))
        else $error("major end did not reload count or set done");
    major_irq_a: assert property (r.st == ST_WBACK && r.ci[r.ch] == 15'h0001 &&
                                  r.imaj[r.ch] |=> r.irq[r.ch])
        else $error("major end with enable did not flag interrupt");
    retire_idle_a: assert property (r.st == ST_WBACK |=> r.st == ST_IDLE ##1
                                    (r.st == ST_LOAD || !$past(gv)))
        else $error("engine did not return to arbitration");
    single_run_a: assert property ($onehot0(r.act))
        else $error("more than one channel active");
endmodule
`default_nettype wire

// ===== bench/dma_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// bus slave memory: byte at address x holds x[7:0]
// ************************************************
module dma_slave_model (
    input  wire logic        i_clk,
    input  wire logic [1:0]  i_lat,
    input  wire logic        i_rd_req,
    input  wire logic [31:0] i_rd_addr,
    output logic             o_rd_ack,
    output logic [31:0]      o_rd_data,
    input  wire logic        i_wr_req,
    output logic             o_wr_ack
);
    logic [1:0] rc;
    logic [1:0] wc;
    // one-cycle acks, reads after i_lat wait cycles and writes after one more; slow writes make the buffer fill
    always_ff @(posedge i_clk) begin
        rc       <= (i_rd_req && !o_rd_ack) ? rc + 2'h1 : 2'h0;
        wc       <= (i_wr_req && !o_wr_ack) ? wc + 2'h1 : 2'h0;
        o_rd_ack <= i_rd_req && !o_rd_ack && rc >= i_lat;
        o_wr_ack <= i_wr_req && !o_wr_ack && wc >= i_lat + 2'h1;
    end
    // outside the ack cycle the data is inverted, so stale bytes never match
    assign o_rd_data = {i_rd_addr[7:0] + 8'h3, i_rd_addr[7:0] + 8'h2,
                        i_rd_addr[7:0] + 8'h1, i_rd_addr[7:0]} ^ {32{!o_rd_ack}};
endmodule
`default_nettype wire

// ===== bench/dma_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dma_engine_bench;
    import dma_pkg::*;
    logic        clk = 0, rst_n = 0, we = 0, grr = 0, rd_ack, wr_ack, rrq, wrq, busy;
    logic [2:0]  a0, a1, cur;
    logic [3:0]  sel = 0, gp = 0;
    logic [1:0]  lat = 0;
    logic [31:0] dat = 0, rd_data, wd, sa, ed;
    logic [7:0]  hen = 0, hrq = 0, clr = 0, st, act, dn, irq, hack;
    addr_t       ra, wa;
    width_t      rw, ww;
    int          err_total = 0, cmp_count = 0, wn, i, j, k, r, m, n;
    // ********************************
    // rows: ten descriptor fields, then expected done
    // ********************************
    logic [31:0] rows [3][11] = '{
        '{32'h1000, 32'h1, 32'h0, 32'hFFFFFFF0, 32'h2000, 32'h4, 32'h2, 32'hFFFFFFF0,
          32'h10, 32'h00010001, 32'h1},
        '{32'h12345670, 32'h4, 32'h22, 32'h0, 32'h3000, 32'h4, 32'h2, 32'h0,
          32'h20, 32'h00020002, 32'h0},
        '{32'h40, 32'h2, 32'h1, 32'h0, 32'h5000, 32'h4, 32'h2, 32'h0,
          32'h8, 32'h00010001, 32'h1}};
    always #10 clk = ~clk;
    dma_engine dma_engine_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_DESC_WE(we),
        .I_DESC_CH(3'h0), .I_DESC_SEL(sel), .I_DESC_DATA(dat), .I_GRP_RR(grr), .I_CH_RR(1'b0),
        .I_CH_PRIO(16'h0), .I_GRP_PRIO(gp), .I_HW_REQUEST_ENABLE(hen), .I_HW_REQ(hrq),
        .I_IRQ_CLR(clr), .O_RD_ADDR(ra), .O_RD_WIDTH(rw), .O_RD_REQ(rrq), .I_RD_ACK(rd_ack),
        .I_RD_DATA(rd_data), .O_WR_ADDR(wa), .O_WR_WIDTH(ww), .O_WR_DATA(wd), .O_WR_REQ(wrq),
        .I_WR_ACK(wr_ack), .O_START(st), .O_ACTIVE(act), .O_DONE(dn),
        .O_CHANNEL_IRQ_FLAG(irq), .O_HW_ACK(hack), .O_BUSY(busy), .O_CUR_CH(cur));
    dma_slave_model dma_slave_model_inst (.i_clk(clk), .i_lat(lat), .i_rd_req(rrq),
        .i_rd_addr(ra), .o_rd_ack(rd_ack), .o_rd_data(rd_data), .i_wr_req(wrq),
        .o_wr_ack(wr_ack));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task summarize;
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task wdesc(input logic [3:0] s, input logic [31:0] d);
        @(negedge clk);
        we = 1; sel = s; dat = d;
        @(negedge clk);
        we = 0;
    endtask
    // bounded wait for the engine to fall idle; a hang ends the run
    task wait_idle;
        repeat (4) @(negedge clk);
        for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
        if (busy !== 1'b0) begin
            err_total++;
            summarize;
        end
    endtask
    // every destination word is rebuilt from the source walk, modulo included
    // looked at mid-cycle, while the acknowledged write still stands
    always @(negedge clk) if (rst_n && wrq && wr_ack) begin
        ed = 0;
        for (j = 0; j < 4; j += 1 << rows[r][2][2:0]) begin
            for (k = 0; k < (1 << rows[r][2][2:0]); k++) ed[8*(j+k)+:8] = sa[7:0] + k;
            m = rows[r][2][7:3];
            sa = (m == 0) ? sa + rows[r][1] : (sa & ~((32'h1 << m) - 1)) |
                 ((sa + rows[r][1]) & ((32'h1 << m) - 1));
        end
        chk(wa, rows[r][4] + wn * rows[r][5]);
        chk(ww, rows[r][6][2:0]);
        chk(wd, ed);
        wn++;
    end
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1;
        chk({busy, st, act, dn, irq}, 0);
        for (r = 0; r < 3; r++) begin
            lat = r; wn = 0; sa = rows[r][0]; clr = 8'hFF;
            for (j = 0; j < 10; j++) wdesc(j[3:0], rows[r][j]);
            clr = 0;
            wdesc(4'hA, 32'h3);
            chk(st[0], 1'b1);
            wait_idle;
            chk(wn, rows[r][8] / 4);
            chk({act[0], dn[0], irq[0]}, {1'b0, rows[r][10][0], rows[r][10][0]});
        end
        // arbitration between channel 1 (group 0) and channel 6 (group 1)
        hen = 8'h42;
        for (m = 0; m < 3; m++) begin
            grr = (m == 2); gp = m ? 4'h4 : 4'h1; n = 0;
            @(negedge clk) hrq = 8'h42;
            for (k = 0; k < 500 && n < 2; k++) begin
                @(negedge clk);
                if (hack !== 8'h0) begin a1 = a0; a0 = cur; n++; end
            end
            hrq = 0;
            wait_idle;
            if (m == 2) chk(a0 ^ a1, 3'h7);
            else chk({a1, a0}, m ? 6'h36 : 6'h09);
        end
        hen = 0; hrq = 8'hFF;
        repeat (10) @(negedge clk);
        chk(busy, 0);
        summarize;
    end
endmodule
`default_nettype wire
